// [src/dcsb_cfg.svh]
// Constants of the dual-channel safety shut-off monitor.
// Assumes inclusion by bare name from every file that uses its macros.
`ifndef DCSB_CFG_SVH
`define DCSB_CFG_SVH
// Clock rate and documented times in their own units
`define DCSB_CLK_HZ 10000000
`define DCSB_GLITCH_US 500
`define DCSB_MISMATCH_S 10
`define DCSB_TICK_US 1000
`define DCSB_US_PER_S 1000000
// Register byte offsets
`define DCSB_OFS_CTRL 5'h00
`define DCSB_OFS_STATUS 5'h04
`define DCSB_OFS_IRQSTAT 5'h08
`define DCSB_OFS_IRQMASK 5'h0C
`define DCSB_OFS_CMD 5'h10
// Control fields and writable mask
`define DCSB_CTRL_STOP 0
`define DCSB_CTRL_UTIL 1
`define DCSB_CTRL_DLY_LSB 8
`define DCSB_CTRL_DLY_MSB 15
`define DCSB_CTRL_MASK 32'h0000FF03
`define DCSB_CTRL_RST 32'h00000000
// Command strobes
`define DCSB_CMD_ON 0
`define DCSB_CMD_OFF 1
`define DCSB_CMD_ACLR 2
// Status fields
`define DCSB_ST_SHUT 0
`define DCSB_ST_AON 1
`define DCSB_ST_BON 2
`define DCSB_ST_RDY 3
`define DCSB_ST_TALARM 4
`define DCSB_ST_EDM 5
`define DCSB_ST_LOCK 6
`define DCSB_ST_PWR 7
// Interrupt events
`define DCSB_IRQ_TRIP 0
`define DCSB_IRQ_TALARM 1
`define DCSB_IRQ_RDY 2
`define DCSB_IRQ_W 3
`define DCSB_IRQ_RST 3'h0
`endif

// [src/dcsb_filter.sv]
// One safety channel: two-flop synchroniser and OFF-glitch filter.
// Assumes an asynchronous pin level, 1 = channel ON (closed).
`include "dcsb_cfg.svh"
`default_nettype none
module dcsb_filter #(
  parameter int unsigned LIMIT = 5000
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pinIn,
  output var logic onOut
);
  import dcsb_pkg::*;

  logic sync1_ff;  // First stage, read only by second
  logic sync2_ff;  // Second stage, safe to use
  logic [31:0] lowCnt_ff;  // Consecutive OFF samples
  logic on_ff;  // Filtered channel state

  // Synchroniser; resets to ON since motor power is off anyway
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= pinIn;
      sync2_ff <= sync1_ff;
    end
  end

  // Short OFF pulses never reach the decision logic
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lowCnt_ff <= 32'h0;
      on_ff <= 1'b1;
    end else if (sync2_ff) begin
      lowCnt_ff <= 32'h0;
      on_ff <= 1'b1;
    end else if (lowCnt_ff < LIMIT) begin
      lowCnt_ff <= lowCnt_ff + 32'h1;
    end else begin
      on_ff <= 1'b0;
    end
  end

  assign onOut = on_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_off_after_limit;
    $fell(on_ff) |-> ($past(lowCnt_ff) == LIMIT) && !$past(sync2_ff);
  endproperty
  a_off_after_limit: assert property (p_off_after_limit)
    else $error("Channel went OFF before the glitch limit");

  property p_on_follows;
    sync2_ff |=> on_ff && (lowCnt_ff == 32'h0);
  endproperty
  a_on_follows: assert property (p_on_follows)
    else $error("Channel did not follow synchronised ON");
endmodule : dcsb_filter
`default_nettype wire

// [src/dcsb_pkg.sv]
// Types shared by the safety monitor files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dcsb_pkg;
  typedef logic [4:0] dcsb_addr_t;  // Avalon byte address
  typedef logic [31:0] dcsb_word_t;  // Bus data word
  typedef logic [3:0] dcsb_be_t;  // Byte enables
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_OFFDLY, ST_SHUT} dcsb_state_e;
endpackage : dcsb_pkg
`default_nettype wire

// [src/dcsb_top.sv]
// Dual-channel safety shut-off monitor with Avalon-MM register slave.
// Assumes asynchronous safety pins (1 = ON) and a master on mclk that
// holds each request until it samples waitrequest low.
//
// Behaviour
// - Either channel OFF requests motor shut-off
// - Both OFF: power removed within 20 ms
// - OFF pulses up to 0.5 ms ignored
// - Shut-off stays active in utility modes
// - Utility run locked until cancel and re-entry
// - Ready held OFF in hardware baseblock
// - Ready ON in baseblock with both ON
// - Shut-off drops brake release, ignores delay
// - Dynamic brake stop if stop method selects
// - No alarm output in hardware baseblock
// - Monitor output ON only when both OFF
// - Channel mismatch over 10 s raises alarm
// - Leave hardware baseblock on servo-off, both ON
// - Monitor output follows inputs within 20 ms
// - Baseblock status bit set while shut off
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`include "dcsb_cfg.svh"
`default_nettype none
module dcsb_top #(
  parameter int unsigned GLITCH_CYC =
    int'((64'(`DCSB_GLITCH_US) * 64'(`DCSB_CLK_HZ)) / 64'(`DCSB_US_PER_S)),
  parameter int unsigned MISMATCH_CYC =
    int'(64'(`DCSB_MISMATCH_S) * 64'(`DCSB_CLK_HZ)),
  parameter int unsigned TICK_CYC =
    int'((64'(`DCSB_TICK_US) * 64'(`DCSB_CLK_HZ)) / 64'(`DCSB_US_PER_S))
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire dcsb_pkg::dcsb_addr_t avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire dcsb_pkg::dcsb_word_t avsWritedata,
  input wire dcsb_pkg::dcsb_be_t avsByteenable,
  output var dcsb_pkg::dcsb_word_t avsReaddata,
  output var logic avsWaitrequest,
  input wire logic safetyInputA,
  input wire logic safetyInputB,
  output var logic motorPowerOut,
  output var logic servoReadyOut,
  output var logic brakeReleaseOut,
  output var logic dynBrakeOut,
  output var logic servoAlarmOut,
  output var logic externalMonitorOut,
  output var logic irqOut
);
  import dcsb_pkg::*;

  // Byte-lane merge of a write into an old word
  function automatic dcsb_word_t beMerge(dcsb_word_t oldW, dcsb_word_t newW,
                                         dcsb_be_t be);
    dcsb_word_t res;
    res = oldW;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = newW[i*8 +: 8];
      end
    end
    return res;
  endfunction : beMerge

  logic aOn;  // Filtered channel A, 1 = ON
  logic bOn;  // Filtered channel B, 1 = ON
  logic shutReq;  // Shut-off request
  logic bothOff;  // Both channels OFF

  // Each channel synchronised and filtered on its own
  dcsb_filter #(.LIMIT(GLITCH_CYC)) u_filtA (
    .mclk(mclk),
    .nrst(nrst),
    .pinIn(safetyInputA),
    .onOut(aOn)
  );
  dcsb_filter #(.LIMIT(GLITCH_CYC)) u_filtB (
    .mclk(mclk),
    .nrst(nrst),
    .pinIn(safetyInputB),
    .onOut(bOn)
  );

  assign shutReq = !aOn || !bOn;
  assign bothOff = !aOn && !bOn;

  // Bus slave signals
  logic waitreq_ff;  // Waitrequest, low for one cycle per access
  dcsb_word_t rdata_ff;  // Read data, loaded in the first cycle
  dcsb_word_t ctrl_ff;  // Control word
  logic wrEn;  // Write takes effect this edge
  logic rdFirst;  // First cycle of a read
  dcsb_word_t wd;  // Write data with disabled lanes zeroed
  logic cmdOn;  // Servo-on command strobe
  logic cmdOff;  // Servo-off command strobe
  logic cmdAclr;  // Alarm clear strobe

  assign wrEn = avsWrite && !waitreq_ff;
  assign rdFirst = avsRead && waitreq_ff;
  assign wd = beMerge(32'h0, avsWritedata, avsByteenable);
  assign cmdOn = wrEn && (avsAddress == `DCSB_OFS_CMD) && wd[`DCSB_CMD_ON];
  assign cmdOff = wrEn && (avsAddress == `DCSB_OFS_CMD) && wd[`DCSB_CMD_OFF];
  assign cmdAclr = wrEn && (avsAddress == `DCSB_OFS_CMD) && wd[`DCSB_CMD_ACLR];

  // Fixed one wait cycle keeps the slave free of any back-to-back hazard
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      waitreq_ff <= 1'b1;
    end else if ((avsRead || avsWrite) && waitreq_ff) begin
      waitreq_ff <= 1'b0;
    end else begin
      waitreq_ff <= 1'b1;
    end
  end

  // Control word; reserved bits stay zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_ff <= `DCSB_CTRL_RST;
    end else if (wrEn && (avsAddress == `DCSB_OFS_CTRL)) begin
      ctrl_ff <= beMerge(ctrl_ff, avsWritedata, avsByteenable) & `DCSB_CTRL_MASK;
    end
  end

  logic stopMethod;  // 1 = dynamic brake on shut-off
  logic utilActive;  // Restricted utility function running
  logic [7:0] brakeDelay;  // Brake-to-servo-off delay in ms
  assign stopMethod = ctrl_ff[`DCSB_CTRL_STOP];
  assign utilActive = ctrl_ff[`DCSB_CTRL_UTIL];
  assign brakeDelay = ctrl_ff[`DCSB_CTRL_DLY_MSB:`DCSB_CTRL_DLY_LSB];

  // Millisecond tick for the brake delay
  logic [31:0] tickCnt_ff;
  logic msTick;
  assign msTick = (tickCnt_ff == TICK_CYC - 1);
  always_ff @(posedge mclk) begin
    if (!nrst || msTick) begin
      tickCnt_ff <= 32'h0;
    end else begin
      tickCnt_ff <= tickCnt_ff + 32'h1;
    end
  end

  // Channel mismatch watchdog; catches a broken wire on one channel
  logic [31:0] misCnt_ff;
  logic timingAlarm_ff;
  logic misHit;
  assign misHit = (aOn != bOn) && (misCnt_ff == MISMATCH_CYC - 1);
  always_ff @(posedge mclk) begin
    if (!nrst || (aOn == bOn)) begin
      misCnt_ff <= 32'h0;
    end else if (misCnt_ff < MISMATCH_CYC) begin
      misCnt_ff <= misCnt_ff + 32'h1;
    end
  end

  // Alarm latch; a new mismatch wins over a clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      timingAlarm_ff <= 1'b0;
    end else if (misHit) begin
      timingAlarm_ff <= 1'b1;
    end else if (cmdAclr) begin
      timingAlarm_ff <= 1'b0;
    end
  end

  // Utility lock: set wins over cancel
  logic utilLock_ff;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      utilLock_ff <= 1'b0;
    end else if (utilActive && shutReq) begin
      utilLock_ff <= 1'b1;
    end else if (!utilActive) begin
      utilLock_ff <= 1'b0;
    end
  end

  // Main sequence
  dcsb_state_e state_ff;
  dcsb_state_e nxt_state;
  logic [7:0] dlyCnt_ff;  // Elapsed ms of brake delay
  logic dlyDone;
  assign dlyDone = (dlyCnt_ff >= brakeDelay);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (shutReq) begin
          nxt_state = ST_SHUT;
        end else if (cmdOn && !utilLock_ff && !timingAlarm_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (shutReq) begin
          nxt_state = ST_SHUT;
        end else if (cmdOff || timingAlarm_ff) begin
          nxt_state = ST_OFFDLY;
        end
      end
      ST_OFFDLY: begin
        // Shut-off overrides the brake delay at once
        if (shutReq) begin
          nxt_state = ST_SHUT;
        end else if (dlyDone) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SHUT: begin
        // Servo-on is ignored here; only servo-off with both ON exits
        if (cmdOff && !shutReq) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_SHUT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Brake delay counter runs only while waiting to cut power
  always_ff @(posedge mclk) begin
    if (!nrst || (state_ff != ST_OFFDLY)) begin
      dlyCnt_ff <= 8'h0;
    end else if (msTick && !dlyDone) begin
      dlyCnt_ff <= dlyCnt_ff + 8'h1;
    end
  end

  // Drive outputs, all registered; all but the monitor output (from bothOff) come from the next state
  logic motorPower_ff;
  logic brakeRelease_ff;
  logic servoReady_ff;
  logic servoAlarm_ff;
  logic extMon_ff;
  logic dynBrake_ff;
  logic nxtReady;
  assign nxtReady = (nxt_state == ST_IDLE) && aOn && bOn && !timingAlarm_ff;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      motorPower_ff <= 1'b0;
      brakeRelease_ff <= 1'b0;
      servoReady_ff <= 1'b0;
      servoAlarm_ff <= 1'b0;
      extMon_ff <= 1'b0;
    end else begin
      motorPower_ff <= (nxt_state == ST_RUN) || (nxt_state == ST_OFFDLY);
      brakeRelease_ff <= (nxt_state == ST_RUN);
      servoReady_ff <= nxtReady;
      servoAlarm_ff <= timingAlarm_ff && (nxt_state != ST_SHUT);
      extMon_ff <= bothOff;
    end
  end

  // Dynamic brake only when a powered motor is tripped
  always_ff @(posedge mclk) begin
    if (!nrst || (nxt_state != ST_SHUT)) begin
      dynBrake_ff <= 1'b0;
    end else if (stopMethod && motorPower_ff && (state_ff != ST_SHUT)) begin
      dynBrake_ff <= 1'b1;
    end
  end

  // Status word for software
  dcsb_word_t statusWord;
  always_comb begin
    statusWord = 32'h0;
    statusWord[`DCSB_ST_SHUT] = (state_ff == ST_SHUT);
    statusWord[`DCSB_ST_AON] = aOn;
    statusWord[`DCSB_ST_BON] = bOn;
    statusWord[`DCSB_ST_RDY] = servoReady_ff;
    statusWord[`DCSB_ST_TALARM] = timingAlarm_ff;
    statusWord[`DCSB_ST_EDM] = extMon_ff;
    statusWord[`DCSB_ST_LOCK] = utilLock_ff;
    statusWord[`DCSB_ST_PWR] = motorPower_ff;
  end

  // Interrupt status, mask and output; events win over clears
  logic [`DCSB_IRQ_W-1:0] irqStat_ff;
  logic [`DCSB_IRQ_W-1:0] irqMask_ff;
  logic [`DCSB_IRQ_W-1:0] irqEvt;
  logic [`DCSB_IRQ_W-1:0] irqClr;
  logic [`DCSB_IRQ_W-1:0] nxt_irqStat;
  logic irq_ff;
  always_comb begin
    irqEvt = '0;
    irqEvt[`DCSB_IRQ_TRIP] = (nxt_state == ST_SHUT) && (state_ff != ST_SHUT);
    irqEvt[`DCSB_IRQ_TALARM] = misHit && !timingAlarm_ff;
    irqEvt[`DCSB_IRQ_RDY] = nxtReady && !servoReady_ff;
    irqClr = '0;
    if (wrEn && (avsAddress == `DCSB_OFS_IRQSTAT)) begin
      irqClr = wd[`DCSB_IRQ_W-1:0];
    end
    nxt_irqStat = (irqStat_ff & ~irqClr) | irqEvt;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irqStat_ff <= `DCSB_IRQ_RST;
      irqMask_ff <= `DCSB_IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      irqStat_ff <= nxt_irqStat;
      if (wrEn && (avsAddress == `DCSB_OFS_IRQMASK)) begin
        irqMask_ff <= avsByteenable[0] ? avsWritedata[`DCSB_IRQ_W-1:0] : irqMask_ff;
      end
      irq_ff <= |(nxt_irqStat & irqMask_ff);
    end
  end

  // Read data; unmapped and command offsets read zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_ff <= 32'h0;
    end else if (rdFirst) begin
      case (avsAddress)
        `DCSB_OFS_CTRL: rdata_ff <= ctrl_ff;
        `DCSB_OFS_STATUS: rdata_ff <= statusWord;
        `DCSB_OFS_IRQSTAT: rdata_ff <= 32'(irqStat_ff);
        `DCSB_OFS_IRQMASK: rdata_ff <= 32'(irqMask_ff);
        default: rdata_ff <= 32'h0;
      endcase
    end
  end

  assign avsReaddata = rdata_ff;
  assign avsWaitrequest = waitreq_ff;
  assign motorPowerOut = motorPower_ff;
  assign servoReadyOut = servoReady_ff;
  assign brakeReleaseOut = brakeRelease_ff;
  assign dynBrakeOut = dynBrake_ff;
  assign servoAlarmOut = servoAlarm_ff;
  assign externalMonitorOut = extMon_ff;
  assign irqOut = irq_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_either_off;
    shutReq |=> (state_ff == ST_SHUT);
  endproperty
  a_either_off: assert property (p_either_off)
    else $error("Channel OFF did not enter hardware baseblock");

  property p_power_cut;
    bothOff |=> !motorPower_ff && !brakeRelease_ff;
  endproperty
  a_power_cut: assert property (p_power_cut)
    else $error("Motor power not removed with both channels OFF");

  property p_util_shut;
    (utilActive && shutReq) |=> utilLock_ff && (state_ff == ST_SHUT);
  endproperty
  a_util_shut: assert property (p_util_shut)
    else $error("Shut-off not active in utility mode");

  sequence s_locked_idle;
    utilLock_ff && (state_ff == ST_IDLE) && cmdOn;
  endsequence
  property p_util_lock;
    s_locked_idle |=> (state_ff != ST_RUN);
  endproperty
  a_util_lock: assert property (p_util_lock)
    else $error("Locked utility run resumed");

  property p_ready_shut;
    (state_ff == ST_SHUT) |-> !servoReady_ff && !servoAlarm_ff;
  endproperty
  a_ready_shut: assert property (p_ready_shut)
    else $error("Ready or alarm asserted in hardware baseblock");

  property p_ready_idle;
    ((nxt_state == ST_IDLE) && aOn && bOn && !timingAlarm_ff) |=> servoReady_ff;
  endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("Ready missing in baseblock with both ON");

  sequence s_trip;
    (state_ff != ST_SHUT) && motorPower_ff && shutReq && stopMethod;
  endsequence
  property p_dyn_brake;
    s_trip |=> dynBrake_ff && !brakeRelease_ff;
  endproperty
  a_dyn_brake: assert property (p_dyn_brake)
    else $error("Trip did not apply dynamic brake and drop brake");

  property p_edm;
    $changed(bothOff) |=> (extMon_ff == $past(bothOff)) [*2];
  endproperty
  a_edm: assert property (p_edm)
    else $error("Monitor output wrong for channel combination");

  property p_mismatch;
    misHit |=> timingAlarm_ff;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("Mismatch did not raise timing alarm");

  sequence s_exit;
    (state_ff == ST_SHUT) && cmdOff && !shutReq;
  endsequence
  property p_shut_hold;
    ((state_ff == ST_SHUT) && !(cmdOff && !shutReq)) |=> (state_ff == ST_SHUT);
  endproperty
  a_shut_hold: assert property (p_shut_hold)
    else $error("Hardware baseblock left without servo-off");

  property p_shut_exit;
    s_exit |=> (state_ff == ST_IDLE);
  endproperty
  a_shut_exit: assert property (p_shut_exit)
    else $error("Hardware baseblock left wrongly");

  property p_status_bit;
    (rdFirst && (avsAddress == `DCSB_OFS_STATUS)) |=>
      (rdata_ff[`DCSB_ST_SHUT] == $past(state_ff == ST_SHUT));
  endproperty
  a_status_bit: assert property (p_status_bit)
    else $error("Baseblock status bit wrong");
endmodule : dcsb_top
`default_nettype wire

// [verif/dcsb_safety_unit.sv]
// Behavioural safety unit that drives the two redundant safety channels.
// Assumes the bench calls its tasks just after a rising edge of mclk.
`default_nettype none
module dcsb_safety_unit (
  input wire logic mclk,
  output var logic pinA,
  output var logic pinB
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts closed at power-up, so the drive may start at once
  initial begin
    pinA = 1'b1;
    pinB = 1'b1;
  end
  // One request moves both channels; B may lag, as real relays do
  task automatic setBoth(input logic lvl, input int skew);
    @(posedge mclk);
    pinA <= lvl;
    repeat (skew) @(posedge mclk);
    pinB <= lvl;
  endtask : setBoth
  // A single channel only, used on purpose to mimic a wiring fault
  task automatic setOne(input logic chanB, input logic lvl);
    @(posedge mclk);
    if (chanB) begin
      pinB <= lvl;
    end else begin
      pinA <= lvl;
    end
  endtask : setOne
  // Contact bounce: both open for len cycles, then closed again
  task automatic bounce(input int len);
    @(posedge mclk);
    pinA <= 1'b0;
    pinB <= 1'b0;
    repeat (len) @(posedge mclk);
    pinA <= 1'b1;
    pinB <= 1'b1;
  endtask : bounce
endmodule : dcsb_safety_unit
`default_nettype wire

// [verif/dcsb_top_tb.sv]
// Self-checking bench for the dual-channel safety shut-off monitor.
// Assumes dcsb_top and the safety unit model; counts are shortened.
`include "dcsb_cfg.svh"
`default_nettype none
module dcsb_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dcsb_pkg::*;
  localparam int unsigned GLITCH = 8; // Short filter, keeps the run brief
  localparam int unsigned MISMATCH = 50; // Short channel-mismatch limit
  localparam int unsigned TICK = 4; // Short millisecond tick
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  dcsb_addr_t avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  dcsb_word_t avsWritedata = '0;
  dcsb_be_t avsByteenable = '0;
  dcsb_word_t avsReaddata;
  logic avsWaitrequest;
  logic pinA, pinB; // Safety channels from the unit model
  logic pwr, rdy, brk, dynBrk, alarmPin, extMon, irqOut; // Design outputs
  logic [6:0] outs; // Output levels gathered for one wait task
  int badCount = 0;
  int comparisons = 0;
  assign outs = {irqOut, extMon, alarmPin, dynBrk, brk, rdy, pwr};
  // Clock at 10 MHz
  always #50 mclk = ~mclk;
  dcsb_safety_unit u_unit (.mclk(mclk), .pinA(pinA), .pinB(pinB));
  dcsb_top #(.GLITCH_CYC(GLITCH), .MISMATCH_CYC(MISMATCH), .TICK_CYC(TICK)) u_dut (
    .mclk(mclk), .nrst(nrst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .safetyInputA(pinA), .safetyInputB(pinB), .motorPowerOut(pwr),
    .servoReadyOut(rdy), .brakeReleaseOut(brk), .dynBrakeOut(dynBrk),
    .servoAlarmOut(alarmPin), .externalMonitorOut(extMon), .irqOut(irqOut));
  // Monitor output is on only when both channels are open
  function automatic logic edmExp(input logic a, input logic b);
    return !a && !b;
  endfunction : edmExp
  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic chkB(input string what, input logic exp, input logic got);
    check(what, 32'(exp), 32'(got));
  endtask : chkB
  // One Avalon transfer; held until waitrequest is seen low
  task automatic busXfer(input logic wr, input dcsb_addr_t a, input dcsb_word_t d,
                         input dcsb_be_t be, output dcsb_word_t rd);
    int n;
    n = 0;
    @(posedge mclk);
    avsAddress <= a;
    avsWritedata <= d;
    avsByteenable <= be;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    chkB("bus answer", 1'b1, n < 50);
  endtask : busXfer
  task automatic wr(input dcsb_addr_t a, input dcsb_word_t d);
    dcsb_word_t x;
    busXfer(1'b1, a, d, 4'hF, x);
  endtask : wr
  task automatic rdReg(input dcsb_addr_t a, output dcsb_word_t rd);
    busXfer(1'b0, a, '0, 4'hF, rd);
  endtask : rdReg
  // Bounded wait for an output level, then compare it
  task automatic waitOut(input int idx, input logic exp, input int maxc, input string what);
    int n;
    n = 0;
    while (outs[idx] !== exp && n < maxc) begin
      @(posedge mclk);
      n++;
    end
    chkB(what, exp, outs[idx]);
  endtask : waitOut
  // Verdict; the only place the run ends
  task automatic finishTest();
    $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finishTest
  // Hang guard, far beyond the several hundred cycles the tests need
  initial begin : watchdog
    repeat (20000) @(posedge mclk);
    badCount++;
    finishTest();
  end
  // Main sequence
  initial begin : mainSeq
    dcsb_word_t rd;
    int len;
    void'($urandom(32'h6E22DEE9));
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    // Reset values, unmapped and write-only places
    rdReg(`DCSB_OFS_CTRL, rd);
    check("ctrl reset", `DCSB_CTRL_RST, rd);
    // Only lane 1 enabled: the delay field lands, lane 0 keeps its zero
    busXfer(1'b1, `DCSB_OFS_CTRL, 32'h0000FFFF, 4'h2, rd);
    rdReg(`DCSB_OFS_CTRL, rd);
    check("ctrl lane 1", 32'h0000FF00, rd);
    wr(5'h14, 32'hFFFFFFFF);
    rdReg(5'h14, rd);
    check("unmapped", 32'h0, rd);
    rdReg(`DCSB_OFS_CMD, rd);
    check("cmd read", 32'h0, rd);
    waitOut(1, 1'b1, 6, "ready at reset");
    wr(`DCSB_OFS_IRQMASK, 32'h7);
    // Running motor must ride through short bounces
    wr(`DCSB_OFS_CMD, 32'h1);
    waitOut(0, 1'b1, 6, "power on");
    for (int i = 0; i < 6; i++) begin
      len = (i == 0) ? GLITCH : ($urandom % GLITCH) + 1;
      u_unit.bounce(len);
      repeat (GLITCH + 4) @(posedge mclk);
      chkB("power after bounce", 1'b1, pwr);
      chkB("monitor after bounce", edmExp(1'b1, 1'b1), extMon);
    end
    // Trip of a powered motor, long brake delay and dynamic braking set
    wr(`DCSB_OFS_CTRL, 32'hFFFFFF01);
    rdReg(`DCSB_OFS_CTRL, rd);
    check("ctrl mask", 32'hFFFFFF01 & `DCSB_CTRL_MASK, rd);
    // Clear the ready event left from reset so the trip alone raises irq
    wr(`DCSB_OFS_IRQSTAT, 32'h7);
    waitOut(6, 1'b0, 4, "irq clear before trip");
    u_unit.setBoth(1'b0, $urandom % 4);
    waitOut(0, 1'b0, GLITCH + 12, "power trip");
    chkB("brake on trip", 1'b0, brk);
    chkB("dyn brake", 1'b1, dynBrk);
    chkB("ready in trip", 1'b0, rdy);
    chkB("alarm in trip", 1'b0, alarmPin);
    waitOut(5, edmExp(1'b0, 1'b0), 6, "monitor both off");
    waitOut(6, 1'b1, 4, "irq trip");
    rdReg(`DCSB_OFS_STATUS, rd);
    chkB("shutdown bit", 1'b1, rd[`DCSB_ST_SHUT]);
    wr(`DCSB_OFS_CMD, 32'h1);
    wr(`DCSB_OFS_CMD, 32'h2);
    u_unit.setBoth(1'b1, 0);
    waitOut(5, 1'b0, 8, "monitor back");
    chkB("power refused", 1'b0, pwr);
    chkB("still locked out", 1'b0, rdy);
    wr(`DCSB_OFS_CMD, 32'h2);
    waitOut(1, 1'b1, 4, "ready after off");
    chkB("dyn released", 1'b0, dynBrk);
    wr(`DCSB_OFS_IRQSTAT, 32'h7);
    waitOut(6, 1'b0, 4, "irq cleared");
    // One channel open: trip, quiet monitor, then mismatch alarm
    for (int i = 0; i < 2; i++) begin
      u_unit.setOne(i[0], 1'b0);
      repeat (MISMATCH + GLITCH + 10) @(posedge mclk);
      rdReg(`DCSB_OFS_STATUS, rd);
      chkB("one off shutdown", 1'b1, rd[`DCSB_ST_SHUT]);
      chkB("one off monitor", edmExp(i[0], !i[0]), extMon);
      chkB("timing alarm", 1'b1, rd[`DCSB_ST_TALARM]);
      chkB("alarm pin hidden", 1'b0, alarmPin);
      u_unit.setOne(i[0], 1'b1);
      repeat (GLITCH) @(posedge mclk);
      wr(`DCSB_OFS_CMD, 32'h2);
      waitOut(4, 1'b1, 4, "alarm shown");
      chkB("no ready on alarm", 1'b0, rdy);
      wr(`DCSB_OFS_CMD, 32'h4);
      waitOut(1, 1'b1, 6, "ready after clear");
    end
    // Utility mode with the interrupt masked, then unmasked
    wr(`DCSB_OFS_IRQSTAT, 32'h7);
    wr(`DCSB_OFS_IRQMASK, 32'h0);
    wr(`DCSB_OFS_CTRL, 32'h2);
    wr(`DCSB_OFS_CMD, 32'h1);
    waitOut(0, 1'b1, 6, "utility run");
    u_unit.setBoth(1'b0, 2);
    waitOut(0, 1'b0, GLITCH + 12, "utility trip");
    chkB("coast", 1'b0, dynBrk);
    chkB("irq masked", 1'b0, irqOut);
    wr(`DCSB_OFS_IRQMASK, 32'h7);
    waitOut(6, 1'b1, 4, "irq unmasked");
    u_unit.setBoth(1'b1, 1);
    repeat (GLITCH) @(posedge mclk);
    wr(`DCSB_OFS_CMD, 32'h2);
    wr(`DCSB_OFS_CMD, 32'h1);
    rdReg(`DCSB_OFS_STATUS, rd);
    chkB("utility lock", 1'b1, rd[`DCSB_ST_LOCK]);
    chkB("no restart", 1'b0, pwr);
    wr(`DCSB_OFS_CTRL, 32'h0);
    wr(`DCSB_OFS_CTRL, 32'h2);
    wr(`DCSB_OFS_CMD, 32'h1);
    waitOut(0, 1'b1, 6, "restart after reentry");
    // Ordinary stop: brake first, power held for the delay
    len = ($urandom % 3) + 1;
    wr(`DCSB_OFS_CTRL, 32'(len << 8) | 32'h2);
    wr(`DCSB_OFS_CMD, 32'h2);
    waitOut(2, 1'b0, 4, "brake on stop");
    chkB("power held", 1'b1, pwr);
    waitOut(0, 1'b0, (len + 1) * TICK + 4, "power after delay");
    u_unit.setBoth(1'b0, 0);
    waitOut(5, 1'b1, GLITCH + 8, "monitor stopped trip");
    chkB("no dyn when stopped", 1'b0, dynBrk);
    wr(`DCSB_OFS_IRQSTAT, 32'h7);
    finishTest();
  end
endmodule : dcsb_top_tb
`default_nettype wire
